//--- design/rxdo_defines.svh
// Register map, field positions, reset values and pipeline timing of the receive back end
`ifndef RXDO_DEFINES_SVH
`define RXDO_DEFINES_SVH

`define RXDO_ADDR_CHAN_SEL 8'h05
`define RXDO_ADDR_OFFSET 8'h10
`define RXDO_ADDR_PATH_CFG 8'h40
`define RXDO_ADDR_FS_TRIM 8'h7D
`define RXDO_ADDR_UPDATE 8'hFF

`define RXDO_SEL_NORMAL 8'h00
`define RXDO_SEL_I 8'h01
`define RXDO_SEL_Q 8'h02

`define RXDO_CFG_DEC_EN_BIT 0
`define RXDO_CFG_SINGLE_BIT 1
`define RXDO_CFG_KEEP_Q_BIT 2
`define RXDO_CFG_WIDTH 3

`define RXDO_UPDATE_BIT 0
`define RXDO_OFFSET_WIDTH 6
`define RXDO_FS_TRIM_WIDTH 5

`define RXDO_RST_CHAN_SEL 8'h00
`define RXDO_RST_CFG 3'h1
`define RXDO_RST_FS_TRIM 5'h00
`define RXDO_RST_OFFSET 6'h00

`define RXDO_HB_TAPS 43
`define RXDO_HB_CENTRE 21
`define RXDO_HB_CENTRE_COEF 16384
`define RXDO_HB_SHIFT 15
`define RXDO_ACC_WIDTH 40
`define RXDO_LATENCY_CYCLES 2

`endif

//--- design/rxdo_pkg.sv
// Types shared by the receive decimation and offset back end
package rxdo_pkg;

	typedef struct packed {
		logic keep_q;
		logic single;
		logic dec_en;
	} rxdo_cfg_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rxdo_reg_wr_type;

	typedef enum logic [1:0] {
		RXDO_TGT_NONE,
		RXDO_TGT_I,
		RXDO_TGT_Q
	} rxdo_target_type;

endpackage

//--- design/rxdo_top.sv
// Receive back end: half-band 2x decimators, per-channel offsets, register port
// Function
// - Each channel has bypassable 2x half-band decimator
// - Symmetric 43-tap FIR with listed coefficients
// - Separate offset held for each channel
// - Six-bit offset added at output LSBs
// - Select 0x01 targets I, 0x02 targets Q
// - Write to channel_offset_value stores selected channel offset
// - Offset is two's complement, 0xFE is -2
// - Offsets apply only after update write
// - Select 0x00 restores normal unredirected addressing
// - Single-converter mode powers one channel down
// - Both channels share one sample clock
// - Five-bit full-scale trim field at 0x7D
// - Update needs zero-to-one on bit 0
`timescale 1ns/1ps
`default_nettype none
`include "rxdo_defines.svh"

module rxdo_chan #(
	parameter int W = 12
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic valid_i,
	input wire logic signed [W-1:0] sample_i,
	input wire logic dec_en_i,
	input wire logic active_i,
	input wire logic [`RXDO_OFFSET_WIDTH-1:0] offset_i,
	output logic signed [W-1:0] data_o,
	output logic valid_o
);
	localparam int AW = `RXDO_ACC_WIDTH;

	logic signed [W-1:0] taps_q [`RXDO_HB_TAPS];
	logic phase_q;
	logic fire_q;
	logic signed [AW-1:0] acc;
	logic signed [AW-1:0] filt;
	logic signed [AW-1:0] pre_sum;
	logic signed [W-1:0] sat_val;
	wire logic signed [AW-1:0] max_v = AW'(signed'((2 ** (W - 1)) - 1));
	wire logic signed [AW-1:0] min_v = -AW'(signed'(2 ** (W - 1)));
	wire logic signed [AW-1:0] offs_ext = AW'(signed'(offset_i));

	function automatic logic signed [15:0] hb_coef(input int k);
		case (k)
			0: hb_coef = 16'sd12;
			1: hb_coef = -16'sd32;
			2: hb_coef = 16'sd72;
			3: hb_coef = -16'sd140;
			4: hb_coef = 16'sd252;
			5: hb_coef = -16'sd422;
			6: hb_coef = 16'sd682;
			7: hb_coef = -16'sd1086;
			8: hb_coef = 16'sd1778;
			9: hb_coef = -16'sd3284;
			10: hb_coef = 16'sd10364;
			default: hb_coef = 16'sd0;
		endcase
	endfunction

	// Folded sum uses the mirror symmetry; odd-index taps other than the centre are zero
	always_comb begin
		logic signed [AW-1:0] pair;
		pair = '0;
		acc = AW'(signed'(`RXDO_HB_CENTRE_COEF)) * AW'(taps_q[`RXDO_HB_CENTRE]);
		for (int k = 0; k < 11; k++) begin
			pair = AW'(taps_q[2 * k]) + AW'(taps_q[`RXDO_HB_TAPS - 1 - 2 * k]);
			acc = acc + AW'(hb_coef(k)) * pair;
		end
	end

	// Bypass takes the newest sample straight through
	assign filt = dec_en_i ? (acc >>> `RXDO_HB_SHIFT) : AW'(taps_q[0]);
	// Offset sits on the LSBs, sign-extended, so 6'h3E subtracts two
	assign pre_sum = filt + offs_ext;
	// Saturate instead of wrapping so an offset near full scale cannot flip the sign
	assign sat_val = (pre_sum > max_v) ? W'(max_v) : (pre_sum < min_v) ? W'(min_v) : W'(pre_sum);

	wire logic take = valid_i && active_i;

	// Taps freeze while the channel is powered down, so it resumes from its last history
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < `RXDO_HB_TAPS; i++) begin
				taps_q[i] <= '0;
			end
		end else if (take) begin
			taps_q[0] <= sample_i;
			for (int i = 1; i < `RXDO_HB_TAPS; i++) begin
				taps_q[i] <= taps_q[i-1];
			end
		end
	end

	// Fires on every sample in bypass, on the second of each pair when decimating
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase_q <= 1'b0;
			fire_q <= 1'b0;
		end else begin
			fire_q <= take && (!dec_en_i || phase_q);
			if (take) begin
				phase_q <= dec_en_i ? !phase_q : 1'b0;
			end
		end
	end

	// A powered-down channel drives zeros so stale data is never taken for live samples
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			data_o <= '0;
			valid_o <= 1'b0;
		end else begin
			valid_o <= fire_q;
			if (!active_i) begin
				data_o <= '0;
			end else if (fire_q) begin
				data_o <= sat_val;
			end
		end
	end
endmodule

module rxdo_top
	import rxdo_pkg::*;
#(
	parameter int W = 12
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	output logic REG_RVALID_O,
	input wire logic ADC_VALID_I,
	input wire logic [W-1:0] ADC_I_DATA_I,
	input wire logic [W-1:0] ADC_Q_DATA_I,
	output logic RX_VALID_O,
	output logic [W-1:0] RX_I_DATA_O,
	output logic [W-1:0] RX_Q_DATA_O,
	output logic RX_I_PWRDN_O,
	output logic RX_Q_PWRDN_O,
	output logic [`RXDO_FS_TRIM_WIDTH-1:0] FULL_SCALE_TRIM_O
);
	localparam int OW = `RXDO_OFFSET_WIDTH;

	logic [7:0] chan_sel_q;
	rxdo_cfg_type cfg_q;
	logic [`RXDO_FS_TRIM_WIDTH-1:0] fs_trim_q;
	logic update_q;
	logic [OW-1:0] stage_i_q;
	logic [OW-1:0] stage_q_q;
	logic [OW-1:0] i_channel_offset_q;
	logic [OW-1:0] q_channel_offset_q;
	logic [7:0] rdata_d;
	logic signed [W-1:0] i_out;
	logic signed [W-1:0] q_out;
	logic i_valid;
	logic q_valid;
	rxdo_reg_wr_type wr;
	rxdo_target_type target;

	assign wr = '{addr: REG_ADDR_I, data: REG_WDATA_I};
	// Offset accesses only land while a channel is addressed
	assign target = (chan_sel_q == `RXDO_SEL_I) ? RXDO_TGT_I :
			(chan_sel_q == `RXDO_SEL_Q) ? RXDO_TGT_Q : RXDO_TGT_NONE;

	// Unmapped writes match none of these strobes and simply fall through
	wire logic wr_sel = REG_WR_I && (wr.addr == `RXDO_ADDR_CHAN_SEL);
	wire logic wr_offs = REG_WR_I && (wr.addr == `RXDO_ADDR_OFFSET);
	wire logic wr_cfg = REG_WR_I && (wr.addr == `RXDO_ADDR_PATH_CFG);
	wire logic wr_trim = REG_WR_I && (wr.addr == `RXDO_ADDR_FS_TRIM);
	wire logic wr_upd = REG_WR_I && (wr.addr == `RXDO_ADDR_UPDATE);
	wire logic upd_rise = wr_upd && wr.data[`RXDO_UPDATE_BIT] && !update_q;
	wire logic i_active = !(cfg_q.single && cfg_q.keep_q);
	wire logic q_active = !(cfg_q.single && !cfg_q.keep_q);
	wire logic stage_i_wr = wr_offs && (target == RXDO_TGT_I);
	wire logic stage_q_wr = wr_offs && (target == RXDO_TGT_Q);

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			chan_sel_q <= `RXDO_RST_CHAN_SEL;
		end else if (wr_sel) begin
			chan_sel_q <= wr.data;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			cfg_q <= `RXDO_RST_CFG;
		end else if (wr_cfg) begin
			cfg_q <= wr.data[`RXDO_CFG_WIDTH-1:0];
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			fs_trim_q <= `RXDO_RST_FS_TRIM;
		end else if (wr_trim) begin
			fs_trim_q <= wr.data[`RXDO_FS_TRIM_WIDTH-1:0];
		end
	end

	// The stored bit is the edge reference, so a host must write 0 before the next update
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			update_q <= 1'b0;
		end else if (wr_upd) begin
			update_q <= wr.data[`RXDO_UPDATE_BIT];
		end
	end

	// Staged offsets reach the datapath only on the update edge, so both channels switch together
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			stage_i_q <= `RXDO_RST_OFFSET;
			stage_q_q <= `RXDO_RST_OFFSET;
		end else begin
			if (stage_i_wr) begin
				stage_i_q <= wr.data[OW-1:0];
			end
			if (stage_q_wr) begin
				stage_q_q <= wr.data[OW-1:0];
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			i_channel_offset_q <= `RXDO_RST_OFFSET;
			q_channel_offset_q <= `RXDO_RST_OFFSET;
		end else if (upd_rise) begin
			i_channel_offset_q <= stage_i_q;
			q_channel_offset_q <= stage_q_q;
		end
	end

	// Offset reads show the staged value, not the one in use, until the next update
	wire logic [7:0] offs_rd = (target == RXDO_TGT_I) ? 8'(signed'(stage_i_q)) :
			(target == RXDO_TGT_Q) ? 8'(signed'(stage_q_q)) : 8'h00;

	always_comb begin
		case (REG_ADDR_I)
			`RXDO_ADDR_CHAN_SEL: rdata_d = chan_sel_q;
			`RXDO_ADDR_OFFSET: rdata_d = offs_rd;
			`RXDO_ADDR_PATH_CFG: rdata_d = {5'h00, cfg_q};
			`RXDO_ADDR_FS_TRIM: rdata_d = {3'h0, fs_trim_q};
			`RXDO_ADDR_UPDATE: rdata_d = {7'h00, update_q};
			default: rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			REG_RDATA_O <= 8'h00;
			REG_RVALID_O <= 1'b0;
		end else begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I) begin
				REG_RDATA_O <= rdata_d;
			end
		end
	end

	// One sample strobe drives both channels, keeping I and Q in lockstep
	rxdo_chan #(.W(W)) u_chan_i (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.valid_i(ADC_VALID_I),
		.sample_i(signed'(ADC_I_DATA_I)),
		.dec_en_i(cfg_q.dec_en),
		.active_i(i_active),
		.offset_i(i_channel_offset_q),
		.data_o(i_out),
		.valid_o(i_valid)
	);

	rxdo_chan #(.W(W)) u_chan_q (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.valid_i(ADC_VALID_I),
		.sample_i(signed'(ADC_Q_DATA_I)),
		.dec_en_i(cfg_q.dec_en),
		.active_i(q_active),
		.offset_i(q_channel_offset_q),
		.data_o(q_out),
		.valid_o(q_valid)
	);

	assign RX_I_DATA_O = i_out;
	assign RX_Q_DATA_O = q_out;
	// Either channel may be the live one in single-converter mode
	assign RX_VALID_O = i_valid || q_valid;
	assign RX_I_PWRDN_O = !i_active;
	assign RX_Q_PWRDN_O = !q_active;
	assign FULL_SCALE_TRIM_O = fs_trim_q;
endmodule
`default_nettype wire

//--- sim/rxdo_checker.sv
// Port-level assertions for the receive back end
`timescale 1ns/1ps
`default_nettype none
`include "rxdo_defines.svh"
module rxdo_checker #(
	parameter int W = 12
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic REG_RVALID_O,
	input wire logic ADC_VALID_I,
	input wire logic RX_VALID_O,
	input wire logic [W-1:0] RX_Q_DATA_O,
	input wire logic RX_I_PWRDN_O,
	input wire logic RX_Q_PWRDN_O,
	input wire logic [4:0] FULL_SCALE_TRIM_O
);
	// Shadow of the decimator enable, so rate checks know the mode
	logic dec_q;
	always_ff @(posedge SYS_CLK_I) begin
		if (!RST_N_I)
			dec_q <= 1'h1;
		else if (REG_WR_I && REG_ADDR_I == `RXDO_ADDR_PATH_CFG)
			dec_q <= REG_WDATA_I[`RXDO_CFG_DEC_EN_BIT];
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	read_answer_a: assert property (REG_RD_I |=> REG_RVALID_O) else $error("read not answered");
	trim_store_a: assert property (REG_WR_I && REG_ADDR_I == `RXDO_ADDR_FS_TRIM
		|=> FULL_SCALE_TRIM_O == $past(REG_WDATA_I[4:0])) else $error("trim not stored");
	lockstep_valid_a: assert property (RX_VALID_O |-> $past(ADC_VALID_I, 2)) else $error("stray output");
	bypass_rate_a: assert property (ADC_VALID_I && !dec_q |-> ##2 RX_VALID_O) else $error("bypass drop");
	halved_rate_a: assert property (dec_q && RX_VALID_O |=> !RX_VALID_O) else $error("rate not halved");
	one_down_a: assert property (!(RX_I_PWRDN_O && RX_Q_PWRDN_O)) else $error("both down");
	down_zero_a: assert property (RX_VALID_O && $past(RX_Q_PWRDN_O, 3)
		|-> RX_Q_DATA_O == 0) else $error("down channel not zero");
	down_cause_a: assert property ($rose(RX_Q_PWRDN_O)
		|-> $past(REG_WR_I && REG_ADDR_I == `RXDO_ADDR_PATH_CFG)) else $error("power down uncaused");
	cover property (REG_RVALID_O);
	cover property (RX_VALID_O && !dec_q);
	cover property (RX_VALID_O && RX_Q_PWRDN_O);
	cover property (RX_VALID_O && RX_I_PWRDN_O);
endmodule
bind rxdo_top rxdo_checker #(.W(W)) rxdo_checker_inst (
	.SYS_CLK_I(SYS_CLK_I),
	.RST_N_I(RST_N_I),
	.REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I),
	.REG_WR_I(REG_WR_I),
	.REG_RD_I(REG_RD_I),
	.REG_RVALID_O(REG_RVALID_O),
	.ADC_VALID_I(ADC_VALID_I),
	.RX_VALID_O(RX_VALID_O),
	.RX_Q_DATA_O(RX_Q_DATA_O),
	.RX_I_PWRDN_O(RX_I_PWRDN_O),
	.RX_Q_PWRDN_O(RX_Q_PWRDN_O),
	.FULL_SCALE_TRIM_O(FULL_SCALE_TRIM_O)
);
`default_nettype wire

//--- sim/rxdo_sink.sv
// Baseband sink: collects every output sample pair
`timescale 1ns/1ps
`default_nettype none
module rxdo_sink #(
	parameter int W = 12
) (
	input wire logic clk_i,
	input wire logic valid_i,
	input wire logic [W-1:0] i_i,
	input wire logic [W-1:0] q_i
);
	// Queues, not checks, so the bench owns every verdict
	logic [W-1:0] gi[$];
	logic [W-1:0] gq[$];
	always @(posedge clk_i) begin
		if (valid_i) begin
			gi.push_back(i_i);
			gq.push_back(q_i);
		end
	end
endmodule
`default_nettype wire

//--- sim/rxdo_tb_top.sv
// Bench: register sequences and sample streams against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module rxdo_tb_top;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, av = 0, rv, ov, pi, pq;
	logic [7:0] addr = 0, wd = 0, rdat;
	logic [11:0] di = 0, dq = 0, oi, oq;
	logic [4:0] trim;
	int bad_count = 0, n_checks = 0, seed = 98, kc, oi_m, oq_m, t, hi[$], hq[$], ei[$], eq[$];
	int cf[11] = '{10364, -3284, 1778, -1086, 682, -422, 252, -140, 72, -32, 12};
	always #4 clk = ~clk;
	rxdo_top #(.W(12)) rxdo_top_inst (.SYS_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdat), .REG_RVALID_O(rv), .ADC_VALID_I(av), .ADC_I_DATA_I(di),
		.ADC_Q_DATA_I(dq), .RX_VALID_O(ov), .RX_I_DATA_O(oi), .RX_Q_DATA_O(oq), .RX_I_PWRDN_O(pi),
		.RX_Q_PWRDN_O(pq), .FULL_SCALE_TRIM_O(trim));
	rxdo_sink #(.W(12)) rxdo_sink_inst (.clk_i(clk), .valid_i(ov), .i_i(oi), .q_i(oq));
	task automatic chk(input bit ok, input string m);
		n_checks++;
		if (!ok) begin
			bad_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic close_out();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic rst();
		rst_n <= 0;
		repeat (2) @(posedge clk);
		rst_n <= 1;
		kc = 0;
		oi_m = 0;
		oq_m = 0;
		hi.delete();
		hq.delete();
	endtask
	task automatic wrr(input logic [7:0] a, d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, e);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 chk(rv === 1 && rdat === e, "readback");
	endtask
	// Newest sample first; an empty slot counts as zero, as after reset
	function automatic int fir(input int h[$]);
		int s = 0, d;
		for (int j = 0; j < h.size() && j < 43; j++) begin
			d = j > 21 ? j - 21 : 21 - j;
			s += h[j] * (d == 0 ? 16384 : d % 2 ? cf[(d - 1) / 2] : 0);
		end
		return s >>> 15;
	endfunction
	function automatic int sat(input int v);
		return v > 2047 ? 2047 : v < -2048 ? -2048 : v;
	endfunction
	// pd: 0 both channels live, 1 Q powered down, 2 I powered down
	task automatic run(input int n, input bit dec, input int pd);
		int x, y;
		for (int k = 0; k < n; k++) begin
			x = $random(seed) % 2048;
			y = $random(seed) % 2048;
			@(posedge clk);
			av <= 1;
			di <= x[11:0];
			dq <= y[11:0];
			hi.push_front(x);
			hq.push_front(y);
			kc++;
			if (!dec || kc % 2 == 0) begin
				ei.push_back(pd == 2 ? 0 : sat((dec ? fir(hi) : x) + oi_m));
				eq.push_back(pd == 1 ? 0 : sat((dec ? fir(hq) : y) + oq_m));
			end
		end
		@(posedge clk);
		av <= 0;
		repeat (3) @(posedge clk);
		#1 chk(rxdo_sink_inst.gi.size() == ei.size(), "sample count");
		while (ei.size() > 0) begin
			chk(rxdo_sink_inst.gi.pop_front() === 12'(ei.pop_front()), "I sample");
			chk(rxdo_sink_inst.gq.pop_front() === 12'(eq.pop_front()), "Q sample");
		end
	endtask
	initial begin
		rst();
		run(60, 1, 0);
		foreach (cf[i]) if (i < 6) rdc(i == 1 ? 8'h40 : 8'(i * 15 + 5), i == 1 ? 8'h01 : 8'h00);
		rdc(8'hFF, 8'h00);
		wrr(8'h40, 8'h00);
		wrr(8'h05, 8'h01);
		wrr(8'h10, 8'h06);
		rdc(8'h10, 8'h06);
		wrr(8'h05, 8'h02);
		wrr(8'h10, 8'hFE);
		rdc(8'h10, 8'hFE);
		wrr(8'h05, 8'h00);
		wrr(8'h10, 8'h15);
		rdc(8'h10, 8'h00);
		wrr(8'h05, 8'h01);
		rdc(8'h10, 8'h06);
		wrr(8'h05, 8'h00);
		run(10, 0, 0);
		wrr(8'hFF, 8'h01);
		oi_m = 6;
		oq_m = -2;
		run(10, 0, 0);
		wrr(8'h05, 8'h01);
		wrr(8'h10, 8'h3F);
		wrr(8'h05, 8'h00);
		wrr(8'hFF, 8'h01);
		run(5, 0, 0);
		wrr(8'hFF, 8'h00);
		wrr(8'hFF, 8'h01);
		oi_m = -1;
		run(5, 0, 0);
		t = $random(seed);
		wrr(8'h7D, t[7:0]);
		rdc(8'h7D, {3'h0, t[4:0]});
		chk(trim === t[4:0], "trim output");
		wrr(8'h40, 8'h02);
		#1 chk(pq === 1 && pi === 0, "single mode");
		run(6, 0, 1);
		wrr(8'h40, 8'h06);
		#1 chk(pi === 1 && pq === 0, "single mode I down");
		run(6, 0, 2);
		rst();
		run(8, 1, 0);
		close_out();
	end
endmodule
`default_nettype wire
